// >>> inc/mpg_defs.svh
// Register map, keys, reset values and timing constants of the motor PWM guard block
`ifndef MPG_DEFS_SVH
`define MPG_DEFS_SVH

`define MPG_ADDR_RUN      16'h7405
`define MPG_ADDR_UNLOCK   16'h7409
`define MPG_ADDR_LOADRDY  16'h740A
`define MPG_ADDR_CNT3     16'h7433
`define MPG_ADDR_CNT4     16'h7434
`define MPG_ADDR_PRD3     16'h7438
`define MPG_ADDR_PRD4     16'h7439
`define MPG_ADDR_CTRL3    16'h7440
`define MPG_ADDR_CTRL4    16'h7441
`define MPG_ADDR_DUTY3    16'h7448
`define MPG_ADDR_DUTY4    16'h744C
`define MPG_ADDR_GUARD    16'h7468

`define MPG_UNLOCK_KEY    8'h5A
`define MPG_LOAD_KEY      6'h2A
`define MPG_ZERO16        16'h0000
`define MPG_PERIOD_RST    16'hFFFF
`define MPG_ONE16         16'h0001

`define MPG_SAMPLE_LAST   2'h3
`define MPG_PRESC_EXT     3'h6
`define MPG_PHASE_ON      3'h7
`define MPG_RUN_CH3       3
`define MPG_RUN_CH4       4
`define MPG_RUN_SHARED_HI 2

`endif

// >>> inc/mpg_pkg.sv
// Types shared by the motor PWM guard block
package mpg_pkg;

   typedef enum logic [1:0] {
      GS_IDLE     = 2'b00,
      GS_ACTIVE   = 2'b01,
      GS_PRD_WAIT = 2'b10
   } mpg_guard_state_t;

   typedef struct packed {
      logic       guard_enable;
      logic       freeze_counter_on_guard;
      logic [1:0] phase_disable_select;
      logic       guard_active_status;
      logic       compare_release_enable;
      logic       period_release_enable;
      logic       auto_release_enable;
      logic       guard_irq_enable;
      logic       guard_event_flag;
      logic [1:0] rsv;
      logic [3:0] guard_sample_count;
   } mpg_guard_ctrl_t;

   typedef struct packed {
      logic [10:0] rsv;
      logic        pwm_enable;
      logic        center_mode;
      logic [2:0]  prescaler_select;
   } mpg_chan_ctrl_t;

   typedef struct packed {
      logic [2:0] lower;
      logic [2:0] upper;
   } mpg_phase_t;

   typedef enum logic [1:0] {
      PD_NONE   = 2'b00,
      PD_ALL    = 2'b01,
      PD_PWM    = 2'b10,
      PD_UPLOW  = 2'b11
   } mpg_phase_mode_t;

endpackage

// >>> core/mpg_core.sv
// Two-channel motor PWM timer with overload guard, write unlock and duty load handshake
`timescale 1ns/100ps
`include "mpg_defs.svh"

module mpg_core #(
   parameter int unsigned PRESC_W = 10
) (
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic [15:0]           reg_addr,
   input  wire logic [15:0]           reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output      logic [15:0]           reg_rdata,
   input  wire logic                  guard_input_pin_n,
   input  wire logic                  timer_b_match,
   output      mpg_pkg::mpg_phase_t [1:0] phase_out,
   output      logic                  guard_irq
);
   import mpg_pkg::*;

   // Register state
   logic [4:0]       run_reg;
   logic [1:0]       unlock_reg;
   logic [1:0]       ready_reg;
   mpg_guard_ctrl_t  guard_reg;
   mpg_chan_ctrl_t   ctrl_reg [2];
   logic [15:0]      period_reg [2];
   logic [15:0]      duty_reg [2][3];
   logic [15:0]      duty_act_reg [2][3];
   logic [15:0]      cnt_reg [2];
   logic [1:0]       down_reg;
   logic [PRESC_W-1:0] presc_reg;

   // Guard state
   logic             pin_meta_reg;
   logic             pin_sync_reg;
   logic [1:0]       sample_div_reg;
   logic [3:0]       low_cnt_reg;
   mpg_guard_state_t gstate_reg;
   mpg_guard_state_t gstate_next;
   logic             prd_seen_reg;
   mpg_phase_t [1:0] snap_reg;

   logic             sample_tick;
   logic             overload_seen;
   logic             pin_high;
   logic             protecting;
   logic             freeze;
   logic             wr_guard;
   logic [1:0]       clear_evt;
   logic [1:0]       step;
   logic [16:0]      step_res [2];
   mpg_phase_t [1:0] raw_phase;
   logic [15:0]      rd_mux;

   function automatic logic presc_tick(input logic [2:0] sel, input logic [PRESC_W-1:0] pc);
      logic [PRESC_W-1:0] mask;
      mask = PRESC_W'((32'd1 << (2 * sel)) - 32'd1);
      if (sel >= `MPG_PRESC_EXT)
         return 1'b0;
      return (pc & mask) == '0;
   endfunction

   // Returns {down_next, count_next}
   function automatic logic [16:0] count_step(input logic [15:0] c, input logic [15:0] p,
                                              input logic center, input logic down);
      if (p == `MPG_ZERO16)
         return {1'b0, `MPG_ZERO16};
      if (!center)
         return (c == p) ? {1'b0, `MPG_ZERO16} : {1'b0, 16'(c + `MPG_ONE16)};
      if (!down)
         return (c >= p) ? {1'b1, 16'(c - `MPG_ONE16)} : {1'b0, 16'(c + `MPG_ONE16)};
      return (c == `MPG_ZERO16) ? {1'b0, `MPG_ONE16} : {1'b1, 16'(c - `MPG_ONE16)};
   endfunction

   function automatic logic two_or_more(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic wr_at(input logic [15:0] a);
      return reg_wr && (reg_addr == a);
   endfunction

   // ---------------- Overload pin capture and filter ----------------

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_meta_reg <= 1'b1;
         pin_sync_reg <= 1'b1;
      end else begin
         pin_meta_reg <= guard_input_pin_n;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign sample_tick = (sample_div_reg == `MPG_SAMPLE_LAST);
   assign pin_high    = pin_sync_reg;

   always_ff @(posedge clk) begin
      if (sys_rst)
         sample_div_reg <= '0;
      else
         sample_div_reg <= 2'(sample_div_reg + 2'h1);
   end

   // Saturating run of low samples; reset by a high sample or with the guard off
   always_ff @(posedge clk) begin
      if (sys_rst || !guard_reg.guard_enable) begin
         low_cnt_reg <= '0;
      end else if (sample_tick) begin
         if (pin_sync_reg)
            low_cnt_reg <= '0;
         else if (low_cnt_reg != 4'hF)
            low_cnt_reg <= 4'(low_cnt_reg + 4'h1);
      end
   end

   // A zero sample count is taken as an overload that never goes away
   assign overload_seen = guard_reg.guard_enable &&
                          ((guard_reg.guard_sample_count == 4'h0) ||
                           (low_cnt_reg >= guard_reg.guard_sample_count));

   // ---------------- Guard state machine ----------------

   always_comb begin
      gstate_next = gstate_reg;
      unique case (gstate_reg)
         GS_IDLE: begin
            if (overload_seen)
               gstate_next = GS_ACTIVE;
         end
         GS_ACTIVE: begin
            if (guard_reg.compare_release_enable && timer_b_match)
               gstate_next = GS_IDLE;
            else if (guard_reg.auto_release_enable && pin_high && !overload_seen)
               gstate_next = GS_IDLE;
            else if (guard_reg.period_release_enable && pin_high && !overload_seen)
               gstate_next = GS_PRD_WAIT;
         end
         GS_PRD_WAIT: begin
            if (overload_seen)
               gstate_next = GS_ACTIVE;
            else if (guard_reg.compare_release_enable && timer_b_match)
               gstate_next = GS_IDLE;
            else if (clear_evt[0] && prd_seen_reg)
               gstate_next = GS_IDLE;
         end
         default: gstate_next = GS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst || !guard_reg.guard_enable)
         gstate_reg <= GS_IDLE;
      else
         gstate_reg <= gstate_next;
   end

   // The second counter clear after the pin rises bounds a whole period
   always_ff @(posedge clk) begin
      if (sys_rst || gstate_reg != GS_PRD_WAIT)
         prd_seen_reg <= 1'b0;
      else if (clear_evt[0])
         prd_seen_reg <= 1'b1;
   end

   assign protecting = (gstate_reg != GS_IDLE);
   assign freeze     = protecting && guard_reg.freeze_counter_on_guard;

   // Phase picture taken just before the outputs are disabled
   always_ff @(posedge clk) begin
      if (sys_rst)
         snap_reg <= '0;
      else if (gstate_reg == GS_IDLE)
         snap_reg <= raw_phase;
   end

   // ---------------- Guard control register ----------------

   // Spelled out: a continuous assign would not wake on the bus signals read inside a function
   assign wr_guard = reg_wr && (reg_addr == `MPG_ADDR_GUARD);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         guard_reg <= '0;
      end else begin
         if (wr_guard) begin
            guard_reg.guard_enable            <= reg_wdata[15];
            guard_reg.freeze_counter_on_guard <= reg_wdata[14];
            guard_reg.phase_disable_select    <= reg_wdata[13:12];
            guard_reg.compare_release_enable  <= reg_wdata[10];
            guard_reg.period_release_enable   <= reg_wdata[9];
            guard_reg.auto_release_enable     <= reg_wdata[8];
            guard_reg.guard_irq_enable        <= reg_wdata[7];
            guard_reg.guard_sample_count      <= reg_wdata[3:0];
         end
         guard_reg.rsv                 <= '0;
         guard_reg.guard_active_status <= (gstate_next != GS_IDLE) &&
                                          guard_reg.guard_enable;
         // Setting beats a same-cycle clear so no overload is lost
         if (overload_seen)
            guard_reg.guard_event_flag <= 1'b1;
         else if (wr_guard && reg_wdata[6])
            guard_reg.guard_event_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst)
         guard_irq <= 1'b0;
      else
         guard_irq <= guard_reg.guard_event_flag && guard_reg.guard_irq_enable;
   end

   // ---------------- Unlock, run and load-ready registers ----------------

   // A keyed write loads both enables, hence the read-OR-write habit
   always_ff @(posedge clk) begin
      if (sys_rst)
         unlock_reg <= '0;
      else if (wr_at(`MPG_ADDR_UNLOCK) && reg_wdata[15:8] == `MPG_UNLOCK_KEY)
         unlock_reg <= reg_wdata[1:0];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run_reg <= '0;
      end else if (wr_at(`MPG_ADDR_RUN)) begin
         if (unlock_reg[0])
            run_reg[`MPG_RUN_CH3] <= reg_wdata[`MPG_RUN_CH3];
         if (unlock_reg[1])
            run_reg[`MPG_RUN_CH4] <= reg_wdata[`MPG_RUN_CH4];
         if (|unlock_reg)
            run_reg[`MPG_RUN_SHARED_HI:0] <= reg_wdata[`MPG_RUN_SHARED_HI:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ready_reg <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (wr_at(`MPG_ADDR_LOADRDY) && reg_wdata[7:2] == `MPG_LOAD_KEY)
               ready_reg[c] <= reg_wdata[c];
            else if (clear_evt[c])
               ready_reg[c] <= 1'b0;
         end
      end
   end

   // ---------------- Channel settings ----------------

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++)
            ctrl_reg[c] <= '0;
      end else begin
         if (wr_at(`MPG_ADDR_CTRL3) && unlock_reg[0])
            ctrl_reg[0] <= {11'h000, reg_wdata[4:0]};
         if (wr_at(`MPG_ADDR_CTRL4) && unlock_reg[1])
            ctrl_reg[1] <= {11'h000, reg_wdata[4:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++)
            period_reg[c] <= `MPG_PERIOD_RST;
      end else begin
         if (wr_at(`MPG_ADDR_PRD3))
            period_reg[0] <= reg_wdata;
         if (wr_at(`MPG_ADDR_PRD4))
            period_reg[1] <= reg_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++)
            for (int k = 0; k < 3; k++)
               duty_reg[c][k] <= `MPG_ZERO16;
      end else begin
         for (int k = 0; k < 3; k++) begin
            if (wr_at(16'(`MPG_ADDR_DUTY3 + k)) && !ready_reg[0])
               duty_reg[0][k] <= reg_wdata;
            if (wr_at(16'(`MPG_ADDR_DUTY4 + k)) && !ready_reg[1])
               duty_reg[1][k] <= reg_wdata;
         end
      end
   end

   // Compare stage keeps old duties until a whole set is ready
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++)
            for (int k = 0; k < 3; k++)
               duty_act_reg[c][k] <= `MPG_ZERO16;
      end else begin
         for (int c = 0; c < 2; c++)
            if (clear_evt[c] && ready_reg[c])
               for (int k = 0; k < 3; k++)
                  duty_act_reg[c][k] <= duty_reg[c][k];
      end
   end

   // ---------------- Channel counters ----------------

   always_ff @(posedge clk) begin
      if (sys_rst)
         presc_reg <= '0;
      else
         presc_reg <= PRESC_W'(presc_reg + 1'b1);
   end

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         step[c] = run_reg[`MPG_RUN_CH3 + c] && !freeze &&
                   presc_tick(ctrl_reg[c].prescaler_select, presc_reg);
         step_res[c] = count_step(cnt_reg[c], period_reg[c],
                                  ctrl_reg[c].center_mode, down_reg[c]);
         clear_evt[c] = step[c] && (step_res[c][15:0] == `MPG_ZERO16) &&
                        (cnt_reg[c] != `MPG_ZERO16);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         for (int c = 0; c < 2; c++)
            cnt_reg[c] <= `MPG_ZERO16;
         down_reg <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (!run_reg[`MPG_RUN_CH3 + c]) begin
               cnt_reg[c]  <= `MPG_ZERO16;
               down_reg[c] <= 1'b0;
            end else if (step[c]) begin
               cnt_reg[c]  <= step_res[c][15:0];
               down_reg[c] <= step_res[c][16];
            end
         end
      end
   end

   // ---------------- Phase generation and disabling ----------------

   always_comb begin
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 3; k++) begin
            raw_phase[c].upper[k] = ctrl_reg[c].pwm_enable &&
                                    (cnt_reg[c] < duty_act_reg[c][k]);
            raw_phase[c].lower[k] = ctrl_reg[c].pwm_enable &&
                                    !(cnt_reg[c] < duty_act_reg[c][k]);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         phase_out <= '0;
      end else begin
         for (int c = 0; c < 2; c++) begin
            if (!protecting) begin
               phase_out[c] <= raw_phase[c];
            end else begin
               unique case (mpg_phase_mode_t'(guard_reg.phase_disable_select))
                  PD_NONE:  phase_out[c] <= raw_phase[c];
                  PD_ALL:   phase_out[c] <= '0;
                  PD_PWM:   phase_out[c] <= ctrl_reg[c].pwm_enable ? '0 : raw_phase[c];
                  PD_UPLOW: begin
                     if (two_or_more(snap_reg[c].upper))
                        phase_out[c] <= '{lower: 3'h0, upper: `MPG_PHASE_ON};
                     else if (two_or_more(snap_reg[c].lower))
                        phase_out[c] <= '{lower: `MPG_PHASE_ON, upper: 3'h0};
                     else
                        phase_out[c] <= '0;
                  end
               endcase
            end
         end
      end
   end

   // ---------------- Register read ----------------

   always_comb begin
      rd_mux = `MPG_ZERO16;
      unique case (reg_addr)
         `MPG_ADDR_RUN:     rd_mux = {11'h000, run_reg};
         `MPG_ADDR_UNLOCK:  rd_mux = {14'h0000, unlock_reg};
         `MPG_ADDR_LOADRDY: rd_mux = {14'h0000, ready_reg};
         `MPG_ADDR_CNT3:    rd_mux = cnt_reg[0];
         `MPG_ADDR_CNT4:    rd_mux = cnt_reg[1];
         `MPG_ADDR_PRD3:    rd_mux = period_reg[0];
         `MPG_ADDR_PRD4:    rd_mux = period_reg[1];
         `MPG_ADDR_CTRL3:   rd_mux = ctrl_reg[0];
         `MPG_ADDR_CTRL4:   rd_mux = ctrl_reg[1];
         `MPG_ADDR_GUARD:   rd_mux = guard_reg;
         default: begin
            for (int k = 0; k < 3; k++) begin
               if (reg_addr == 16'(`MPG_ADDR_DUTY3 + k))
                  rd_mux = duty_reg[0][k];
               if (reg_addr == 16'(`MPG_ADDR_DUTY4 + k))
                  rd_mux = duty_reg[1][k];
            end
         end
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst)
         reg_rdata <= `MPG_ZERO16;
      else if (reg_rd)
         reg_rdata <= rd_mux;
      else
         reg_rdata <= `MPG_ZERO16;
   end

endmodule

// >>> tb/mpg_monitor.sv
// Port-level assertions for the motor PWM guard core
`timescale 1ns/100ps
`include "mpg_defs.svh"
module mpg_monitor (
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic [15:0]          reg_addr,
   input wire logic [15:0]          reg_wdata,
   input wire logic                 reg_wr,
   input wire logic                 reg_rd,
   input wire logic [15:0]          reg_rdata,
   input wire logic                 guard_input_pin_n,
   input wire logic                 timer_b_match,
   input wire mpg_pkg::mpg_phase_t [1:0] phase_out,
   input wire logic                 guard_irq
);
   import mpg_pkg::*;
   wire rd_g = reg_rd && reg_addr == `MPG_ADDR_GUARD;
   wire rd_u = reg_rd && reg_addr == `MPG_ADDR_UNLOCK;
   wire wr_u = reg_wr && reg_addr == `MPG_ADDR_UNLOCK;
   wire rd_l = reg_rd && reg_addr == `MPG_ADDR_LOADRDY;
   wire wr_l = reg_wr && reg_addr == `MPG_ADDR_LOADRDY;
   wire rd_r = reg_rd && reg_addr == `MPG_ADDR_RUN;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_read_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (reg_rd && reg_addr == 16'h7400
      |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
   a_ready_keybits: assert property (rd_l |=> reg_rdata[15:2] == 14'h0000)
      else $error("load check bits read nonzero");
   a_unlock_rsv: assert property (rd_u |=> reg_rdata[15:2] == 14'h0000)
      else $error("unlock reserved bits nonzero");
   a_run_rsv: assert property (rd_r |=> reg_rdata[15:5] == 11'h000)
      else $error("run reserved bits nonzero");
   // Bus idle cycle between write and read, as the bench tasks leave it
   a_unlock_key: assert property (wr_u && reg_wdata[15:8] == 8'h5A ##1 !reg_wr ##1 rd_u
      |=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3)) else $error("keyed unlock not taken");
   // A counter clear may drop a ready bit, but nothing may raise one unasked
   a_ready_no_stray: assert property (wr_l && reg_wdata[7:2] == 6'h2A ##1 !reg_wr ##1 rd_l
      |=> (reg_rdata[1:0] & ~$past(reg_wdata[1:0], 3)) == 2'h0) else $error("stray ready bit");
   a_irq_follows: assert property (rd_g |=> guard_irq == (reg_rdata[7] & reg_rdata[6]))
      else $error("irq differs from flag and enable");
   a_leg_exclusive: assert property (((phase_out[0].upper & phase_out[0].lower) |
      (phase_out[1].upper & phase_out[1].lower)) == 3'h0) else $error("leg driven both ways");

   cover property ($rose(guard_irq));
   cover property (rd_g ##1 reg_rdata[11]);
   cover property ($fell(phase_out[0].upper[0]));
endmodule

bind mpg_core mpg_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .guard_input_pin_n(guard_input_pin_n), .timer_b_match(timer_b_match),
   .phase_out(phase_out), .guard_irq(guard_irq));

// >>> tb/mpg_stage_model.sv
// Inverter power stage model: overload sense line and shoot-through watch
`timescale 1ns/100ps
module mpg_stage_model (
   input wire logic                 clk,
   input wire logic                 trip,
   input wire mpg_pkg::mpg_phase_t [1:0] phase_out,
   output     logic                 guard_input_pin_n,
   output     logic                 shoot_thru
);
   import mpg_pkg::*;
   logic trip_q = 1'b0;
   logic shoot_q = 1'b0;
   // Sense line has a pull-up, so it reads high whenever the stage is healthy
   assign guard_input_pin_n = ~trip_q;
   assign shoot_thru = shoot_q;
   always @(posedge clk) begin
      trip_q <= trip;
      if ((phase_out[0].upper & phase_out[0].lower) != 3'h0) shoot_q <= 1'b1;
      if ((phase_out[1].upper & phase_out[1].lower) != 3'h0) shoot_q <= 1'b1;
   end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the motor PWM guard core
`timescale 1ns/100ps
`include "mpg_defs.svh"
module tb;
   import mpg_pkg::*;
   localparam logic [15:0] GRD = `MPG_ADDR_GUARD, CNT = `MPG_ADDR_CNT3, UNL = `MPG_ADDR_UNLOCK;
   logic             clk, sys_rst, reg_wr, reg_rd, timer_b_match, trip, guard_irq;
   logic             guard_input_pin_n, shoot_thru, dn;
   logic [15:0]      reg_addr, reg_wdata, reg_rdata, v, p, cfg;
   mpg_phase_t [1:0] phase_out;
   int               n_errors = 0, tests_run = 0, seed = 48, k, m, len;

   mpg_core dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .guard_input_pin_n(guard_input_pin_n), .timer_b_match(timer_b_match),
      .phase_out(phase_out), .guard_irq(guard_irq));
   mpg_stage_model u_stage (.clk(clk), .trip(trip), .phase_out(phase_out),
      .guard_input_pin_n(guard_input_pin_n), .shoot_thru(shoot_thru));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk(d, exp);
   endtask
   task automatic pin(input logic lvl, input int n);
      @(posedge clk);
      trip <= lvl;
      cyc(n);
   endtask
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      cyc(20000);
      n_errors++;
      $display("unexpected at %0t: watchdog ran out", $time);
      wrap_up();
   end

   initial begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, timer_b_match, trip} = 4'h0;
      {reg_addr, reg_wdata} = 32'h0000_0000;
      cyc(10);
      sys_rst <= 1'b0;
      rdchk(`MPG_ADDR_RUN, 16'h0000);
      rdchk(UNL, 16'h0000);
      rdchk(`MPG_ADDR_LOADRDY, 16'h0000);
      rdchk(`MPG_ADDR_PRD3, 16'hFFFF);
      rdchk(GRD, 16'h0000);
      rdchk(16'h7400, 16'h0000);
      $display("test reset values done");
      wr(`MPG_ADDR_RUN, 16'h0008);
      rdchk(`MPG_ADDR_RUN, 16'h0000);
      wr(UNL, 16'h3301);
      rdchk(UNL, 16'h0000);
      wr(UNL, 16'h5A01);
      rd(UNL, v);
      wr(UNL, v | 16'h5A02);
      rdchk(UNL, 16'h0003);
      v = 16'($random(seed));
      wr(`MPG_ADDR_CTRL4, v);
      rdchk(`MPG_ADDR_CTRL4, v & 16'h001F);
      wr(UNL, 16'h5A01);
      wr(`MPG_ADDR_CTRL4, ~v);
      rdchk(`MPG_ADDR_CTRL4, v & 16'h001F);
      $display("test write unlock done");
      wr(`MPG_ADDR_CTRL3, 16'h0010);
      wr(`MPG_ADDR_PRD3, 16'h0005);
      for (k = 0; k < 3; k++) wr(`MPG_ADDR_DUTY3 + 16'(k), 16'hFFFF);
      wr(`MPG_ADDR_LOADRDY, 16'h00A9);
      rdchk(`MPG_ADDR_LOADRDY, 16'h0001);
      wr(`MPG_ADDR_LOADRDY, 16'h0056);
      rdchk(`MPG_ADDR_LOADRDY, 16'h0001);
      wr(`MPG_ADDR_DUTY3, 16'h1234);
      rdchk(`MPG_ADDR_DUTY3, 16'hFFFF);
      wr(`MPG_ADDR_RUN, 16'h0008);
      cyc(30);
      rdchk(`MPG_ADDR_LOADRDY, 16'h0000);
      chk({10'h000, phase_out[0]}, 16'h0007);
      $display("test duty load done");
      wr(CNT, 16'h0100);
      // Reads every second cycle: only center mode shows a fall by exactly two
      for (m = 0; m < 2; m++) begin
         wr(`MPG_ADDR_CTRL3, 16'h0010 | 16'(m << 3));
         dn = 1'b0;
         p = 16'h0000;
         for (k = 0; k < 12; k++) begin
            rd(CNT, v);
            chk({15'h0000, v <= 16'h0005}, 16'h0001);
            if (p == v + 16'h0002) dn = 1'b1;
            p = v;
         end
         chk({15'h0000, dn}, 16'(m));
      end
      wr(`MPG_ADDR_RUN, 16'h0000);
      rdchk(CNT, 16'h0000);
      wr(`MPG_ADDR_RUN, 16'h0008);
      $display("test counters done");
      for (k = 0; k < 4; k++) begin
         cfg = 16'hC182 | 16'(k << 12);
         wr(GRD, cfg);
         pin(1'b1, 30);
         rdchk(GRD, cfg | 16'h0840);
         chk({15'h0000, guard_irq}, 16'h0001);
         rd(CNT, v);
         rdchk(CNT, v);
         chk({10'h000, phase_out[0]}, (k == 1 || k == 2) ? 16'h0000 : 16'h0007);
         pin(1'b0, 30);
         wr(GRD, cfg);
         rdchk(GRD, cfg | 16'h0040);
         wr(GRD, cfg | 16'h0040);
         rdchk(GRD, cfg);
         chk({15'h0000, guard_irq}, 16'h0000);
      end
      for (k = 0; k < 2; k++) begin
         cfg = 16'h8002 | (16'h0400 >> k);
         wr(GRD, cfg);
         pin(1'b1, 30);
         pin(1'b0, 40);
         rdchk(GRD, cfg | ((k == 0) ? 16'h0840 : 16'h0040));
         @(posedge clk);
         timer_b_match <= 1'b1;
         @(posedge clk);
         timer_b_match <= 1'b0;
         cyc(2);
         rdchk(GRD, cfg | 16'h0040);
         wr(GRD, cfg | 16'h0040);
      end
      // Random glitches all shorter than fifteen quarter-rate samples
      wr(GRD, 16'h800F);
      for (k = 0; k < 6; k++) begin
         len = 1 + ($random(seed) & 31);
         pin(1'b1, len);
         pin(1'b0, 10);
      end
      rdchk(GRD, 16'h800F);
      wr(GRD, 16'h000F);
      pin(1'b1, 80);
      rdchk(GRD, 16'h000F);
      pin(1'b0, 10);
      wr(GRD, 16'h8000);
      cyc(20);
      wr(GRD, 16'h8040);
      rd(GRD, v);
      chk(v & 16'h0040, 16'h0040);
      chk({15'h0000, shoot_thru}, 16'h0000);
      $display("test guard done");
      wrap_up();
   end
endmodule
